// [design/usbcfg_defs.svh]
`ifndef USBCFG_DEFS_SVH
`define USBCFG_DEFS_SVH

// Register indices; byte address is four times the index
`define USBCFG_IDX_ADDR_A 8'h10
`define USBCFG_IDX_EP0_A 8'h12
`define USBCFG_IDX_STATUS 8'h1F
`define USBCFG_IDX_EP_DIR 8'h20
`define USBCFG_IDX_ADDR_B 8'h40
`define USBCFG_IDX_EP0_B 8'h42

// Reset values
`define USBCFG_RST_ADDR 8'h00
`define USBCFG_RST_EP0 8'h00
`define USBCFG_RST_STATUS 8'h00
`define USBCFG_RST_EP_DIR 8'h00

// Status/control fields
`define USBCFG_ST_ACTION_MSB 2
`define USBCFG_ST_ACTIVITY 3
`define USBCFG_ST_DMINUS 4
`define USBCFG_ST_DPLUS 5
`define USBCFG_ST_ONE_ADDR 6
`define USBCFG_ST_BIG_FIFO 7

// Address register fields
`define USBCFG_AD_ENABLE 7
`define USBCFG_AD_MSB 6

// Endpoint zero mode fields
`define USBCFG_M0_SETUP 7
`define USBCFG_M0_IN 6
`define USBCFG_M0_OUT 5
`define USBCFG_M0_ACK 4
`define USBCFG_M0_MODE_MSB 3

// FIFO start addresses in user RAM
`define USBCFG_RAM_A8 8'hA8
`define USBCFG_RAM_B0 8'hB0
`define USBCFG_RAM_B8 8'hB8
`define USBCFG_RAM_C0 8'hC0
`define USBCFG_RAM_D8 8'hD8
`define USBCFG_RAM_E0 8'hE0
`define USBCFG_RAM_E8 8'hE8
`define USBCFG_RAM_F0 8'hF0
`define USBCFG_RAM_F8 8'hF8

// CPU stall per byte written by the engine
`define USBCFG_STALL_PER_BYTE 8'h03

`endif

// [design/usbcfg_pkg.sv]
package usbcfg_pkg;

	typedef enum logic [1:0] {
		USBCFG_TOK_SETUP,
		USBCFG_TOK_IN,
		USBCFG_TOK_OUT
	} usbcfg_tok_type;

	typedef struct packed {
		logic valid;
		usbcfg_tok_type kind;
		logic [6:0] addr;
		logic [2:0] endp;
	} usbcfg_token_type;

	typedef struct packed {
		logic valid;
		logic func_b;
		logic [2:0] endp;
	} usbcfg_ack_type;

	typedef struct packed {
		logic hit;
		logic func_b;
		logic [2:0] endp;
		logic [7:0] base;
		logic big;
		logic dir_ok;
	} usbcfg_route_type;

endpackage

// [design/usbcfg_regs.sv]
//Contract
// - Bus activity sets sticky status bit 3
// - Writing 0 clears activity; 1 keeps it
// - Bits 4,5 show live minus/plus lines
// - Emit end-of-packet at each EOF1 point
// - Address registers A, B reset zero, disabled
// - Default: A three endpoints, B two
// - Respond to address only when enabled
// - Status bits 7,6 pick size and addresses
// - Mode 00 maps five 8-byte FIFOs
// - Mode 10 maps mixed 8/32-byte FIFOs
// - Mode 01 one address, five 8-byte FIFOs
// - Mode 11 one address, mixed FIFO sizes
// - Stall CPU three cycles per byte
// - Endpoint zero bidirectional, others firmware-chosen
// - Endpoint mode registers reset to zero
// - Endpoint zero mode fields: tokens, ACK, mode
// - Mode bits steer control endpoint response
// - ACK flag set on ACKed transaction
// - Control action bits zero for normal run
// - Single-address: 0x42 is endpoint three mode
`timescale 1ns/1ps
`include "usbcfg_defs.svh"

module usbcfg_regs
	import usbcfg_pkg::*;
(
	input wire logic sys_clk, // 10 MHz system clock
	input wire logic rst, // Synchronous reset, high
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped
	input wire logic dplus_pin, // Upstream plus line level
	input wire logic dminus_pin, // Upstream minus line level
	input wire logic bus_event, // Engine saw non-idle bus event
	input wire logic eof1_tick, // Frame timer at EOF1
	input wire usbcfg_token_type token, // Decoded token
	input wire usbcfg_ack_type ack, // Transaction ended in ACK
	input wire logic fifo_byte_wr, // Engine wrote a FIFO byte
	output logic eop_req, // Generate end-of-packet
	output logic cpu_stall, // Hold the CPU off the bus
	output logic [2:0] upstream_action, // Forced line state, 0=engine
	output usbcfg_route_type route, // Last matched token route
	output logic [3:0] ep0_mode_a, // a_endpoint_zero response mode
	output logic [3:0] ep0_mode_b // b_endpoint_zero response mode
);

	logic [7:0] addr_a_q;
	logic [7:0] addr_b_q;
	logic [7:0] ep0_a_q;
	logic [7:0] ep0_b_q;
	logic [7:0] status_q;
	logic [7:0] ep_dir_q;
	logic [1:0] dp_sync_q;
	logic [1:0] dm_sync_q;
	logic [7:0] stall_cnt_q;
	logic [31:0] prdata_q;
	logic eop_q;
	usbcfg_route_type route_q;

	logic [9:0] idx;
	logic aligned;
	logic wr_en;
	logic rd_setup;
	logic one_addr;
	logic big_fifo;
	logic match_a;
	logic match_b;
	logic ack_a0;
	logic ack_b0;
	logic ack_a3;
	usbcfg_route_type route_d;

	assign idx = paddr[11:2];
	assign aligned = (paddr[1:0] == 2'b00);
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign one_addr = status_q[`USBCFG_ST_ONE_ADDR];
	assign big_fifo = status_q[`USBCFG_ST_BIG_FIFO];

	function automatic logic is_reg(input logic [9:0] i,
		input logic [7:0] r);
		is_reg = (i == {2'b00, r});
	endfunction

	function automatic logic mapped(input logic [9:0] i);
		mapped = is_reg(i, `USBCFG_IDX_ADDR_A) |
			is_reg(i, `USBCFG_IDX_EP0_A) |
			is_reg(i, `USBCFG_IDX_STATUS) |
			is_reg(i, `USBCFG_IDX_EP_DIR) |
			is_reg(i, `USBCFG_IDX_ADDR_B) |
			is_reg(i, `USBCFG_IDX_EP0_B);
	endfunction

	function automatic logic wr_hit(input logic [7:0] r);
		wr_hit = wr_en & aligned & is_reg(idx, r);
	endfunction

	// FIFO start and size for one endpoint under each configuration
	function automatic logic [8:0] fifo_map(input logic big,
		input logic one, input logic fb, input logic [2:0] ep);
		logic [7:0] b;
		logic w;
		b = `USBCFG_RAM_F8;
		w = 1'b0;
		case ({big, one})
			2'b00: begin
				case ({fb, ep})
					4'b1_001: b = `USBCFG_RAM_D8;
					4'b1_000: b = `USBCFG_RAM_E0;
					4'b0_010: b = `USBCFG_RAM_E8;
					4'b0_001: b = `USBCFG_RAM_F0;
					default: b = `USBCFG_RAM_F8;
				endcase
			end
			2'b10: begin
				case ({fb, ep})
					4'b1_000: b = `USBCFG_RAM_A8;
					4'b1_001: b = `USBCFG_RAM_B0;
					4'b0_001: begin
						b = `USBCFG_RAM_C0;
						w = 1'b1;
					end
					4'b0_010: begin
						b = `USBCFG_RAM_E0;
						w = 1'b1;
					end
					default: b = `USBCFG_RAM_B8;
				endcase
			end
			2'b01: begin
				case (ep)
					3'd4: b = `USBCFG_RAM_D8;
					3'd3: b = `USBCFG_RAM_E0;
					3'd2: b = `USBCFG_RAM_E8;
					3'd1: b = `USBCFG_RAM_F0;
					default: b = `USBCFG_RAM_F8;
				endcase
			end
			default: begin
				case (ep)
					3'd3: b = `USBCFG_RAM_A8;
					3'd4: b = `USBCFG_RAM_B0;
					3'd1: begin
						b = `USBCFG_RAM_C0;
						w = 1'b1;
					end
					3'd2: begin
						b = `USBCFG_RAM_E0;
						w = 1'b1;
					end
					default: b = `USBCFG_RAM_B8;
				endcase
			end
		endcase
		fifo_map = {w, b};
	endfunction

	// Pin levels come from outside the clock domain
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dp_sync_q <= 2'b00;
			dm_sync_q <= 2'b00;
		end else begin
			dp_sync_q <= {dp_sync_q[0], dplus_pin};
			dm_sync_q <= {dm_sync_q[0], dminus_pin};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			addr_a_q <= `USBCFG_RST_ADDR;
			addr_b_q <= `USBCFG_RST_ADDR;
		end else begin
			if (wr_hit(`USBCFG_IDX_ADDR_A))
				addr_a_q <= pwdata[7:0];
			if (wr_hit(`USBCFG_IDX_ADDR_B))
				addr_b_q <= pwdata[7:0];
		end
	end

	// Default bits 7,6 = 0,0 give A three and B two endpoints
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			status_q <= `USBCFG_RST_STATUS;
		end else begin
			if (wr_hit(`USBCFG_IDX_STATUS)) begin
				status_q[7:6] <= pwdata[7:6];
				status_q[2:0] <= pwdata[2:0];
				if (!pwdata[`USBCFG_ST_ACTIVITY])
					status_q[`USBCFG_ST_ACTIVITY] <= 1'b0;
			end
			// Set after clear so a same-cycle event is not lost
			if (bus_event)
				status_q[`USBCFG_ST_ACTIVITY] <= 1'b1;
			status_q[`USBCFG_ST_DMINUS] <= dm_sync_q[1];
			status_q[`USBCFG_ST_DPLUS] <= dp_sync_q[1];
		end
	end

	// Bit n set means endpoint n is IN; endpoint zero ignores it
	always_ff @(posedge sys_clk) begin
		if (rst)
			ep_dir_q <= `USBCFG_RST_EP_DIR;
		else if (wr_hit(`USBCFG_IDX_EP_DIR))
			ep_dir_q <= pwdata[7:0];
	end

	assign match_a = token.valid & addr_a_q[`USBCFG_AD_ENABLE] &
		(token.addr == addr_a_q[`USBCFG_AD_MSB:0]);
	assign match_b = token.valid & ~one_addr & ~match_a &
		addr_b_q[`USBCFG_AD_ENABLE] &
		(token.addr == addr_b_q[`USBCFG_AD_MSB:0]);

	assign ack_a0 = ack.valid & ~ack.func_b & (ack.endp == 3'd0);
	assign ack_b0 = ack.valid & ack.func_b & ~one_addr &
		(ack.endp == 3'd0);
	assign ack_a3 = ack.valid & ~ack.func_b & one_addr &
		(ack.endp == 3'd3);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ep0_a_q <= `USBCFG_RST_EP0;
		end else begin
			if (wr_hit(`USBCFG_IDX_EP0_A))
				ep0_a_q <= pwdata[7:0];
			if (match_a && token.endp == 3'd0) begin
				case (token.kind)
					USBCFG_TOK_SETUP: ep0_a_q[`USBCFG_M0_SETUP] <= 1'b1;
					USBCFG_TOK_IN: ep0_a_q[`USBCFG_M0_IN] <= 1'b1;
					USBCFG_TOK_OUT: ep0_a_q[`USBCFG_M0_OUT] <= 1'b1;
					default: ;
				endcase
			end
			if (ack_a0)
				ep0_a_q[`USBCFG_M0_ACK] <= 1'b1;
		end
	end

	// In single-address layouts this is endpoint three's mode
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ep0_b_q <= `USBCFG_RST_EP0;
		end else begin
			if (wr_hit(`USBCFG_IDX_EP0_B))
				ep0_b_q <= pwdata[7:0];
			if (match_b && token.endp == 3'd0) begin
				case (token.kind)
					USBCFG_TOK_SETUP: ep0_b_q[`USBCFG_M0_SETUP] <= 1'b1;
					USBCFG_TOK_IN: ep0_b_q[`USBCFG_M0_IN] <= 1'b1;
					USBCFG_TOK_OUT: ep0_b_q[`USBCFG_M0_OUT] <= 1'b1;
					default: ;
				endcase
			end
			if (ack_b0 || ack_a3)
				ep0_b_q[`USBCFG_M0_ACK] <= 1'b1;
		end
	end

	always_comb begin
		logic [8:0] m;
		m = fifo_map(big_fifo, one_addr, match_b, token.endp);
		route_d.hit = match_a | match_b;
		route_d.func_b = match_b;
		route_d.endp = token.endp;
		route_d.base = m[7:0];
		route_d.big = m[8];
		route_d.dir_ok = (token.endp == 3'd0) |
			(ep_dir_q[token.endp] == (token.kind == USBCFG_TOK_IN)) &
			(token.kind != USBCFG_TOK_SETUP);
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			route_q <= '0;
		else if (match_a || match_b)
			route_q <= route_d;
	end

	// Accumulates so back-to-back bytes each cost their full stall
	always_ff @(posedge sys_clk) begin
		if (rst)
			stall_cnt_q <= 8'h00;
		else if (fifo_byte_wr)
			stall_cnt_q <= stall_cnt_q + `USBCFG_STALL_PER_BYTE -
				{7'h00, stall_cnt_q != 8'h00};
		else if (stall_cnt_q != 8'h00)
			stall_cnt_q <= stall_cnt_q - 8'h01;
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			eop_q <= 1'b0;
		else
			eop_q <= eof1_tick;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			prdata_q <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_q <= 32'h0000_0000;
			if (aligned) begin
				if (is_reg(idx, `USBCFG_IDX_ADDR_A))
					prdata_q[7:0] <= addr_a_q;
				if (is_reg(idx, `USBCFG_IDX_ADDR_B))
					prdata_q[7:0] <= addr_b_q;
				if (is_reg(idx, `USBCFG_IDX_EP0_A))
					prdata_q[7:0] <= ep0_a_q;
				if (is_reg(idx, `USBCFG_IDX_EP0_B))
					prdata_q[7:0] <= ep0_b_q;
				if (is_reg(idx, `USBCFG_IDX_STATUS))
					prdata_q[7:0] <= status_q;
				if (is_reg(idx, `USBCFG_IDX_EP_DIR))
					prdata_q[7:0] <= ep_dir_q;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~(aligned & mapped(idx));
	assign eop_req = eop_q;
	assign cpu_stall = (stall_cnt_q != 8'h00);
	assign upstream_action = status_q[`USBCFG_ST_ACTION_MSB:0];
	assign route = route_q;
	assign ep0_mode_a = ep0_a_q[`USBCFG_M0_MODE_MSB:0];
	assign ep0_mode_b = ep0_b_q[`USBCFG_M0_MODE_MSB:0];

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_byte_alone;
		fifo_byte_wr && stall_cnt_q == 8'h00 ##1 !fifo_byte_wr [*4];
	endsequence

	AST_ACTIVITY_SET: assert property (
		bus_event |=> status_q[`USBCFG_ST_ACTIVITY])
		else $error("activity flag not set after bus event");

	AST_ACTIVITY_KEEP: assert property (
		wr_hit(`USBCFG_IDX_STATUS) && pwdata[3] && !bus_event |=>
		status_q[3] == $past(status_q[3]))
		else $error("writing one changed activity flag");

	AST_ACTIVITY_CLR: assert property (
		wr_hit(`USBCFG_IDX_STATUS) && !pwdata[3] && !bus_event |=>
		!status_q[3])
		else $error("writing zero did not clear activity flag");

	AST_PIN_LIVE: assert property (
		##3 status_q[`USBCFG_ST_DPLUS] == $past(dplus_pin, 3))
		else $error("plus line bit does not follow pin");

	AST_EOP_AT_EOF1: assert property (
		eof1_tick |=> eop_req ##1 (eop_req == $past(eof1_tick)))
		else $error("end-of-packet not raised at EOF1");

	AST_ENABLE_GATES: assert property (
		!addr_a_q[7] && (addr_b_q[7] == 1'b0) |-> !route_d.hit)
		else $error("token matched a disabled address");

	AST_STALL_THREE: assert property (
		s_byte_alone |-> !cpu_stall)
		else $error("single byte stall not three cycles");

	AST_STALL_HELD: assert property (
		fifo_byte_wr |=> cpu_stall [*3])
		else $error("CPU not stalled after engine byte write");

	AST_ACK_FLAG: assert property (
		ack_a0 |=> ep0_a_q[`USBCFG_M0_ACK])
		else $error("ACK flag not set on ACKed transaction");

	AST_SETUP_FLAG: assert property (
		match_a && token.endp == 3'd0 && token.kind == USBCFG_TOK_SETUP
		|=> ep0_a_q[`USBCFG_M0_SETUP])
		else $error("SETUP flag not set on setup token");

	AST_SINGLE_NO_B: assert property (
		one_addr |-> !match_b)
		else $error("function B matched in single-address mode");

	AST_BIG_FIFO: assert property (
		big_fifo && match_a && token.endp == 3'd1 |=> route.big &&
		route.base == `USBCFG_RAM_C0)
		else $error("a_endpoint_one not mapped to 32-byte FIFO");

endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps

module testbench
	import usbcfg_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, dplus_pin, dminus_pin, bus_event, eof1_tick;
	logic fifo_byte_wr, eop_req, cpu_stall;
	logic [2:0] upstream_action;
	logic [3:0] ep0_mode_a, ep0_mode_b;
	usbcfg_token_type token;
	usbcfg_token_type tok_cmd = '0;
	usbcfg_ack_type ack;
	usbcfg_ack_type ack_cmd = '0;
	usbcfg_route_type route;
	logic byte_cmd = 1'b0;
	logic eof_cmd = 1'b0;
	logic [1:0] line_cmd = 2'b00;
	logic [32:0] exp_q[$];
	logic [31:0] seed = 32'h0000_59ea;
	logic [6:0] ra;
	logic [3:0] md;
	logic [7:0] f;
	int err_count = 0;
	int tests_run = 0;
	int i;

	always #50 sys_clk = ~sys_clk;

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic usbcfg_token_type tk(input usbcfg_tok_type k,
		input logic [6:0] a, input logic [2:0] e);
		return '{1'b1, k, a, e};
	endfunction

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (err_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Upper data bits are random: the block must ignore them
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d, input logic [32:0] e);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= (rnd() & 32'hffff_ff00) | {24'h00_0000, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		if (!w) exp_q.push_back(e);
		do @(posedge sys_clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d, '0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00, {1'b0, 24'h00_0000, e});
	endtask

	task automatic send(input usbcfg_token_type t, input usbcfg_ack_type k,
		input logic b);
		@(posedge sys_clk);
		tok_cmd <= t;
		ack_cmd <= k;
		byte_cmd <= b;
		eof_cmd <= b;
		@(posedge sys_clk);
		tok_cmd <= '0;
		ack_cmd <= '0;
		byte_cmd <= 1'b0;
		eof_cmd <= 1'b0;
	endtask

	// Last argument is {big, dir_ok}
	task automatic rchk(input logic fb, input logic [2:0] e,
		input logic [7:0] b, input logic [1:0] g);
		@(posedge sys_clk);
		#1;
		check({18'h0_0000, route}, {18'h0_0000, 1'b1, fb, e, b, g});
	endtask

	// Read results are matched in issue order
	always @(posedge sys_clk) begin
		if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
			check({pslverr, prdata}, exp_q.pop_front());
		end
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		finish_test();
	end

	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		rd(12'h040, 8'h00);
		rd(12'h100, 8'h00);
		rd(12'h048, 8'h00);
		rd(12'h108, 8'h00);
		rd(12'h07c, 8'h00);
		apb(1'b0, 12'h044, 8'h00, {1'b1, 32'h0000_0000});
		apb(1'b0, 12'h041, 8'h00, {1'b1, 32'h0000_0000});
		ra = 7'(rnd() % 32'd100 + 32'd1);
		md = 4'(rnd());
		send(tk(USBCFG_TOK_SETUP, ra, 3'h0), '0, 1'b0);
		rd(12'h048, 8'h00);
		rd(12'h07c, 8'h08);
		wr(12'h07c, 8'h08);
		rd(12'h07c, 8'h08);
		wr(12'h07c, 8'h00);
		rd(12'h07c, 8'h00);
		@(posedge sys_clk);
		line_cmd <= 2'b10;
		repeat (4) @(posedge sys_clk);
		rd(12'h07c, 8'h20);
		line_cmd <= 2'b01;
		repeat (4) @(posedge sys_clk);
		rd(12'h07c, 8'h10);
		wr(12'h040, {1'b1, ra});
		rd(12'h040, {1'b1, ra});
		wr(12'h048, {4'h0, md});
		@(posedge sys_clk);
		#1;
		check({29'h0000_0000, ep0_mode_a}, {29'h0000_0000, md});
		send(tk(USBCFG_TOK_SETUP, ra + 7'h02, 3'h0), '0, 1'b0);
		rd(12'h048, {4'h0, md});
		for (i = 0; i < 3; i++) begin
			f = 8'he0 << (2 - i);
			send(tk(usbcfg_tok_type'(i), ra, 3'h0), '0, 1'b0);
			rd(12'h048, f | {4'h0, md});
		end
		send('0, '{1'b1, 1'b0, 3'h0}, 1'b0);
		rd(12'h048, 8'hf0 | {4'h0, md});
		wr(12'h100, {1'b1, ra + 7'h01});
		wr(12'h080, 8'h02);
		for (i = 0; i < 4; i++) begin
			wr(12'h07c, {i[1:0], 6'h08});
			send(tk(USBCFG_TOK_OUT, ra, 3'h0), '0, 1'b0);
			rchk(1'b0, 3'h0, i[1] ? 8'hb8 : 8'hf8, 2'b01);
			send(tk(USBCFG_TOK_OUT, ra + 7'(!i[0]), 3'(i[0] * 3)), '0, 1'b0);
			rchk(!i[0], 3'(i[0] * 3), i[1] ? 8'ha8 : 8'he0,
				2'b01);
		end
		send(tk(USBCFG_TOK_IN, ra, 3'h1), '0, 1'b0);
		rchk(1'b0, 3'h1, 8'hc0, 2'b11);
		// Endpoint one is IN, so an OUT token must not pass direction
		send(tk(USBCFG_TOK_OUT, ra, 3'h1), '0, 1'b0);
		rchk(1'b0, 3'h1, 8'hc0, 2'b10);
		wr(12'h108, {4'h0, md});
		@(posedge sys_clk);
		#1;
		check({29'h0000_0000, ep0_mode_b}, {29'h0000_0000, md});
		send('0, '{1'b1, 1'b0, 3'h3}, 1'b0);
		rd(12'h108, 8'h10 | {4'h0, md});
		send('0, '0, 1'b1);
		for (i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			#1;
			check({31'h0, cpu_stall, eop_req},
				{31'h0, 1'(i < 3), 1'(i == 0)});
		end
		wr(12'h07c, 8'h05);
		@(posedge sys_clk);
		#1;
		check({30'h0, upstream_action}, {30'h0, 3'h5});
		wr(12'h07c, 8'h00);
		repeat (2) @(posedge sys_clk);
		finish_test();
	end

	usbcfg_host_model host (
		.sys_clk(sys_clk),
		.tok_cmd(tok_cmd),
		.ack_cmd(ack_cmd),
		.byte_cmd(byte_cmd),
		.eof_cmd(eof_cmd),
		.line_cmd(line_cmd),
		.dplus_pin(dplus_pin),
		.dminus_pin(dminus_pin),
		.bus_event(bus_event),
		.eof1_tick(eof1_tick),
		.token(token),
		.ack(ack),
		.fifo_byte_wr(fifo_byte_wr)
	);

	usbcfg_regs dut (
		.sys_clk(sys_clk),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.dplus_pin(dplus_pin),
		.dminus_pin(dminus_pin),
		.bus_event(bus_event),
		.eof1_tick(eof1_tick),
		.token(token),
		.ack(ack),
		.fifo_byte_wr(fifo_byte_wr),
		.eop_req(eop_req),
		.cpu_stall(cpu_stall),
		.upstream_action(upstream_action),
		.route(route),
		.ep0_mode_a(ep0_mode_a),
		.ep0_mode_b(ep0_mode_b)
	);
endmodule

// [dv/usbcfg_host_model.sv]
`timescale 1ns/1ps

module usbcfg_host_model
	import usbcfg_pkg::*;
(
	input wire logic sys_clk, // System clock
	input wire usbcfg_token_type tok_cmd, // Token to send
	input wire usbcfg_ack_type ack_cmd, // Handshake to send
	input wire logic byte_cmd, // Byte into FIFO
	input wire logic eof_cmd, // Frame point
	input wire logic [1:0] line_cmd, // Line levels, plus/minus
	output logic dplus_pin, // Upstream plus line
	output logic dminus_pin, // Upstream minus line
	output logic bus_event, // Non-idle bus event
	output logic eof1_tick, // Frame timer point
	output usbcfg_token_type token, // Decoded token
	output usbcfg_ack_type ack, // Handshake seen
	output logic fifo_byte_wr // FIFO byte strobe
);
	// Known levels before the first edge
	initial begin
		token = '0;
		ack = '0;
		bus_event = 1'b0;
		eof1_tick = 1'b0;
		fifo_byte_wr = 1'b0;
	end
	// Every token or handshake is traffic on the wire
	always @(posedge sys_clk) begin
		token <= tok_cmd;
		ack <= ack_cmd;
		bus_event <= tok_cmd.valid | ack_cmd.valid;
		fifo_byte_wr <= byte_cmd;
		eof1_tick <= eof_cmd;
	end
	// Pins are asynchronous; they follow line_cmd at once, with no frame gating
	assign dplus_pin = line_cmd[1];
	assign dminus_pin = line_cmd[0];
endmodule
